// ---- bench/caf_msg_source.sv ----
// Purpose: message source standing in for the other bus nodes
// Assumes: go is a one-cycle request from the bench
// Notes: fields are scrambled between messages
`timescale 1ns/100ps
module caf_msg_source (
  input  wire logic        clk,              // clock
  input  wire logic        go,               // send request
  input  wire logic [34:0] msg,              // ext, sid, eid, fifo index
  output logic             msgValid = 1'b0,  // one-cycle strobe
  output logic      [34:0] msgBits = 35'h0   // presented fields
);
  // present on request, invert otherwise so no stale id lingers
  always @(posedge clk) begin
    msgValid <= go;
    msgBits <= go ? msg : ~msgBits;
  end
endmodule // caf_msg_source

// ---- bench/caf_rx_filter_properties.sv ----
// Purpose: bus and accept-path properties of caf_rx_filter
// Assumes: one clock, synchronous active-high reset
// Notes: bound to the top module after endmodule
`timescale 1ns/100ps
module caf_rx_filter_properties (
  input wire logic        clk,       // clock
  input wire logic        srst,      // sync reset
  input wire logic        ce,        // clock enable
  input wire logic        wbCyc,     // bus cycle
  input wire logic        wbStb,     // bus strobe
  input wire logic        wbWe,      // write enable
  input wire logic [9:0]  wbAdr,     // byte address
  input wire logic [31:0] wbDatO,    // read data
  input wire logic        wbAck,     // acknowledge
  input wire logic        msgValid,  // message strobe
  input wire logic        accValid,  // accept pulse
  input wire logic [3:0]  accFilter, // accepting filter
  input wire logic [4:0]  accBuffer  // buffer written
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // id words whose bits 4 and 2 are unbuilt
  wire sidWord = wbAdr[9:2] < 8'h10 || wbAdr[9:2] inside {[8'h20:8'h22]};
  AST_ACK_WAIT: assert property (ce && wbCyc && wbStb && !wbAck |=> wbAck)
    else $error("ack missing after request");
  AST_ACK_PULSE: assert property (ce && wbAck |=> !wbAck)
    else $error("ack longer than one cycle");
  AST_ACK_IDLE: assert property (ce && !(wbCyc && wbStb) |=> !wbAck)
    else $error("ack without request");
  AST_DAT_HIGH: assert property (wbAck |-> wbDatO[31:16] == 16'h0000)
    else $error("upper read half not zero");
  AST_SID_GAP: assert property (wbAck && !wbWe && sidWord
    |-> wbDatO[4] == 1'b0 && wbDatO[2] == 1'b0)
    else $error("unbuilt id bit reads one");
  AST_ACC_CAUSE: assert property (accValid |-> $past(msgValid))
    else $error("accept without message");
  AST_ACC_HOLD: assert property (!accValid |-> $stable({accFilter, accBuffer}))
    else $error("accept outputs moved");
  AST_RST_QUIET: assert property (disable iff (1'b0)
    srst && ce |=> !wbAck && !accValid && accBuffer == 5'h00)
    else $error("outputs active after reset");
endmodule // caf_rx_filter_properties
bind caf_rx_filter caf_rx_filter_properties caf_rx_filter_properties_i (
  .clk(clk), .srst(srst), .ce(ce), .wbCyc(wbCyc), .wbStb(wbStb),
  .wbWe(wbWe), .wbAdr(wbAdr), .wbDatO(wbDatO), .wbAck(wbAck),
  .msgValid(msgValid), .accValid(accValid), .accFilter(accFilter),
  .accBuffer(accBuffer));

// ---- bench/caf_rx_filter_tb.sv ----
// Purpose: self-checking bench for caf_rx_filter
// Assumes: random ids from a fixed seed, no selector code 11
// Notes: a reference filter in the bench predicts every accept
`timescale 1ns/100ps
module caf_rx_filter_tb;
  logic        clk = 1'b0, srst = 1'b1, go = 1'b0, ce = 1'b1;
  logic        wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0;
  logic [3:0]  wbSel = 4'h0, accFilter, bp[16];
  logic [9:0]  wbAdr = 10'h000;
  logic [31:0] wbDatI = 32'h0, wbDatO, ful = 32'h0, ovf = 32'h0;
  logic        wbAck, accValid, msgValid;
  logic [4:0]  accBuffer;
  logic [34:0] msg = 35'h0, msgBits;
  logic [15:0] fs[16], fe[16], ms[3], me[3], en, rdQ[$];
  logic [1:0]  sel[16];
  logic [8:0]  accQ[$];
  int          numErrors = 0, checksDone = 0, cycles = 0;
  localparam logic [7:0] RIX[9] = '{8'h28, 8'h29, 8'h2a, 8'h2c, 8'h30,
                                   8'h31, 8'h32, 8'h33, 8'h3f};
  always #2.5 clk = ~clk;
  caf_rx_filter caf_rx_filter_i (.clk(clk), .srst(srst), .ce(ce),
    .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr),
    .wbSel(wbSel), .wbDatI(wbDatI), .wbDatO(wbDatO), .wbAck(wbAck),
    .msgValid(msgValid), .msgExt(msgBits[34]), .msgSid(msgBits[33:23]),
    .msgEid(msgBits[22:5]), .fifoBufIdx(msgBits[4:0]),
    .accValid(accValid), .accFilter(accFilter), .accBuffer(accBuffer));
  caf_msg_source caf_msg_source_i (.clk(clk), .go(go), .msg(msg),
    .msgValid(msgValid), .msgBits(msgBits));
  task automatic testDone();
    $display("checks %0d errors %0d", checksDone, numErrors);
    if (numErrors == 0 && checksDone > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic check(input string nm, input logic [15:0] seen, exp);
    checksDone++;
    if (seen !== exp)
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    if (seen !== exp)
      numErrors++;
  endtask
  // one classic cycle; reads note their expected data
  task automatic bus(input logic we, input logic [7:0] ix,
                     input logic [15:0] d);
    if (!we) rdQ.push_back(d);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbSel <= 4'hf;
    wbAdr <= {ix, 2'b00};
    wbDatI <= {~d, d};
    do @(posedge clk); while (wbAck !== 1'b1);
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    @(posedge clk);
  endtask
  // reference match of filter k against message m
  function automatic logic hit(int k, logic [34:0] m);
    logic [15:0] s, e;
    s = ms[sel[k]];
    e = me[sel[k]];
    return en[k]
      && ((m[33:23] ^ fs[k][15:5]) & s[15:5]) == 0
      && (!s[3] || m[34] == fs[k][3])
      && (!m[34]
          || ((m[22:5] ^ {fs[k][1:0], fe[k]}) & {s[1:0], e}) == 0);
  endfunction
  task automatic sendMsg(input logic [34:0] m);
    int k;
    logic [4:0] b;
    k = -1;
    for (int i = 15; i >= 0; i--) if (hit(i, m)) k = i;
    if (k >= 0) begin
      b = bp[k] == 4'hf ? m[4:0] : {1'b0, bp[k]};
      accQ.push_back({k[3:0], b});
      ovf[b] = ovf[b] | ful[b];
      ful[b] = 1'b1;
    end
    go <= 1'b1;
    msg <= m;
    @(posedge clk);
    go <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  // compare results with the oldest note; cut a hang short
  always @(posedge clk) begin
    cycles++;
    if (wbAck === 1'b1 && !wbWe && rdQ.size() > 0)
      check("read", wbDatO[15:0], rdQ.pop_front());
    if (accValid === 1'b1)
      check("accept", {7'h0, accFilter, accBuffer},
            accQ.size() ? {7'h0, accQ.pop_front()} : 16'hffff);
    if (cycles == 30000) begin
      numErrors++;
      testDone();
    end
  end
  initial begin
    logic [34:0] m;
    logic [15:0] v, sw[2];
    int j;
    void'($urandom(60));
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    for (int i = 0; i < 9; i++)
      bus(1'b0, RIX[i], i == 2 ? 16'hffff : 16'h0);
    bus(1'b1, 8'h3f, 16'hffff);
    bus(1'b0, 8'h3f, 16'h0000);
    $display("test reset done");
    for (int i = 0; i < 16; i++) begin
      fs[i] = 16'($urandom) & caf_pkg::SID_WMASK;
      fe[i] = 16'($urandom);
      sel[i] = 2'($urandom % 3);
      bp[i] = 4'($urandom);
      sw[i / 8][2 * (i % 8) +: 2] = sel[i];
      bus(1'b1, 8'(i), fs[i]);
      bus(1'b1, 8'h10 + 8'(i), fe[i]);
    end
    for (int i = 0; i < 3; i++) begin
      ms[i] = 16'($urandom);
      me[i] = 16'($urandom);
      bus(1'b1, 8'h20 + 8'(i), ms[i]);
      bus(1'b0, 8'h20 + 8'(i), ms[i] & caf_pkg::SID_WMASK);
      bus(1'b1, 8'h24 + 8'(i), me[i]);
    end
    for (int i = 0; i < 2; i++) begin
      bus(1'b1, 8'h28 + 8'(i), sw[i]);
      bus(1'b0, 8'h28 + 8'(i), sw[i]);
    end
    for (int p = 0; p < 4; p++)
      bus(1'b1, 8'h2c + 8'(p), {bp[4*p+3], bp[4*p+2], bp[4*p+1], bp[4*p]});
    en = 16'($urandom);
    bus(1'b1, 8'h2a, en);
    $display("test setup done");
    repeat (300) begin
      j = $urandom % 16;
      m = {fs[j][3], fs[j][15:5], fs[j][1:0], fe[j], 5'($urandom)};
      m = m ^ (35'h20 << ($urandom % 45));
      sendMsg(m);
    end
    $display("test filtering done");
    // exact-match messages while ce is low must leave no trace
    ce <= 1'b0;
    for (int i = 0; i < 16; i++) begin
      go <= 1'b1;
      msg <= {fs[i][3], fs[i][15:5], fs[i][1:0], fe[i], 5'h00};
      @(posedge clk);
      go <= 1'b0;
      @(posedge clk);
    end
    repeat (2) @(posedge clk);
    ce <= 1'b1;
    $display("test freeze done");
    for (int i = 0; i < 4; i++) begin
      v = i < 2 ? ful[16 * i +: 16] : ovf[16 * (i - 2) +: 16];
      bus(1'b1, 8'h30 + 8'(i), 16'hffff);
      bus(1'b0, 8'h30 + 8'(i), v);
      bus(1'b1, 8'h30 + 8'(i), 16'h0000);
      bus(1'b0, 8'h30 + 8'(i), 16'h0000);
    end
    check("pending", 16'(accQ.size()), 16'h0000);
    $display("test flags done");
    testDone();
  end
endmodule // caf_rx_filter_tb

// ---- design/caf_pkg.sv ----
// Purpose: constants for the acceptance filter and receive status block
// Assumes: word-indexed registers, byte address = index * 4
// Notes: 16-bit registers sit in the low half of each 32-bit word
// Behaviour
// - included lower extended id bits must equal the filter bits to match
// - 2-bit mask selector per filter, two registers, bits 2k+1:2k
// - selector 00, 01, 10 picks mask 0, 1, 2
// - mask standard id bit one includes the bit, zero ignores it
// - mask extended id bits, upper two and lower sixteen, include or ignore
// - qualify bit one: message id type must equal filter type select
// - qualify bit zero: standard or extended accepted when compared bits agree
// - 32 full flags in two registers, set when a buffer is written
// - full flags reset to zero, cleared only by software
// - overflow flag set when a write targets a buffer still full
// - overflow flags reset to zero, cleared only by software
// - mask standard id bits 4 and 2 read as zero
// - included standard id bits must equal the filter bits
// - filter type select: one extended only, zero standard only
// - each filter has an enable, only enabled filters accept
// - 4-bit buffer pointer per filter, 1111 means the receive fifo
package caf_pkg;
  localparam int NUM_FILT = 16;
  localparam int NUM_MASK = 3;
  localparam int NUM_BUF  = 32;
  // word indices of the register map
  localparam logic [7:0] IX_FSID  = 8'h00; // 16 filter std id words
  localparam logic [7:0] IX_FEID  = 8'h10; // 16 filter ext id low words
  localparam logic [7:0] IX_MSID  = 8'h20; // 3 mask std id words
  localparam logic [7:0] IX_MEID  = 8'h24; // 3 mask ext id low words
  localparam logic [7:0] IX_MSEL0 = 8'h28;
  localparam logic [7:0] IX_MSEL1 = 8'h29;
  localparam logic [7:0] IX_FEN   = 8'h2a;
  localparam logic [7:0] IX_BPTR  = 8'h2c; // 4 pointer words
  localparam logic [7:0] IX_FUL0  = 8'h30;
  localparam logic [7:0] IX_FUL1  = 8'h31;
  localparam logic [7:0] IX_OVF0  = 8'h32;
  localparam logic [7:0] IX_OVF1  = 8'h33;
  // field layout of the std id words
  localparam int SID_HI = 15;
  localparam int SID_LO = 5;
  localparam int TYPE_BIT = 3;
  localparam logic [15:0] SID_WMASK = 16'hffeb; // bits 4 and 2 unbuilt
  // reset values and the fifo pointer code
  localparam logic [15:0] RST_ZERO = 16'h0000;
  localparam logic [15:0] RST_FEN  = 16'hffff;
  localparam logic [3:0]  PTR_FIFO = 4'hf;
endpackage

// ---- design/caf_rx_filter.sv ----
// Purpose: acceptance filtering and receive buffer full/overflow flags
// Assumes: message fields arrive from the protocol engine on clk
// Notes: lowest-numbered matching filter wins; flags clear by writing 0
//        selector code 11 acts as mask 2
`timescale 1ns/100ps
module caf_rx_filter (
  input  wire logic        clk,         // 200 MHz clock
  input  wire logic        srst,        // sync reset, active high
  input  wire logic        ce,          // clock enable, freezes state
  input  wire logic        wbCyc,       // wishbone cycle
  input  wire logic        wbStb,       // wishbone strobe
  input  wire logic        wbWe,        // wishbone write enable
  input  wire logic [9:0]  wbAdr,       // wishbone byte address
  input  wire logic [3:0]  wbSel,       // wishbone byte selects
  input  wire logic [31:0] wbDatI,      // wishbone write data
  output logic      [31:0] wbDatO,      // wishbone read data
  output logic             wbAck,       // wishbone acknowledge
  input  wire logic        msgValid,    // one-cycle message strobe
  input  wire logic        msgExt,      // message is extended
  input  wire logic [10:0] msgSid,      // message standard id
  input  wire logic [17:0] msgEid,      // message extended id
  input  wire logic [4:0]  fifoBufIdx,  // buffer the fifo writes next
  output logic             accValid,    // pulse: message accepted
  output logic      [3:0]  accFilter,   // filter that accepted
  output logic      [4:0]  accBuffer    // buffer written
);

  // per-filter and per-mask storage
  logic [15:0] fltStd [caf_pkg::NUM_FILT];
  logic [15:0] fltExt [caf_pkg::NUM_FILT];
  logic [15:0] mskStd [caf_pkg::NUM_MASK];
  logic [15:0] mskExt [caf_pkg::NUM_MASK];
  logic [15:0] mskSel0;
  logic [15:0] mskSel1;
  logic [15:0] filter_accept_enable;
  logic [15:0] bufPtr [4];
  logic [31:0] fullFlags;
  logic [31:0] ovfFlags;

  // byte-lane merge of a 16-bit register write
  function automatic logic [15:0] laneMerge(
    input logic [15:0] old,
    input logic [15:0] dat,
    input logic [1:0]  sel
  );
    laneMerge = {sel[1] ? dat[15:8] : old[15:8],
                 sel[0] ? dat[7:0]  : old[7:0]};
  endfunction

  // write-zero-to-clear with hardware set winning
  function automatic logic [15:0] clrSet(
    input logic [15:0] old,
    input logic [15:0] dat,
    input logic [1:0]  sel,
    input logic        wr,
    input logic [15:0] set
  );
    logic [15:0] keep;
    keep = {(wr && sel[1]) ? dat[15:8] : 8'hff,
            (wr && sel[0]) ? dat[7:0]  : 8'hff};
    clrSet = (old & keep) | set;
  endfunction

  // one filter against the message under one mask
  function automatic logic filterHit(
    input logic [15:0] fs,
    input logic [15:0] fe,
    input logic [15:0] ms,
    input logic [15:0] me,
    input logic        en
  );
    logic [10:0] sidDiff;
    logic [17:0] eidDiff;
    logic        typeOk;
    logic        bitsOk;
    sidDiff = (msgSid ^ fs[caf_pkg::SID_HI:caf_pkg::SID_LO])
            & ms[caf_pkg::SID_HI:caf_pkg::SID_LO];
    eidDiff = (msgEid ^ {fs[1:0], fe}) & {ms[1:0], me};
    // type must agree only when the mask qualifies it
    typeOk = !ms[caf_pkg::TYPE_BIT]
           || (msgExt == fs[caf_pkg::TYPE_BIT]);
    // standard frames compare only the standard bits
    bitsOk = (sidDiff == 11'h000)
           && (!msgExt || eidDiff == 18'h00000);
    filterHit = en && typeOk && bitsOk;
  endfunction

  // mask index for a selector code; reserved 11 falls on mask 2
  function automatic logic [1:0] maskPick(input logic [1:0] code);
    if (code == 2'h0) begin
      maskPick = 2'h0;
    end else if (code == 2'h1) begin
      maskPick = 2'h1;
    end else begin
      maskPick = 2'h2;
    end
  endfunction

  // bus decode
  wire         busReq  = wbCyc && wbStb;
  wire         busWr   = busReq && wbWe && wbAck;
  wire  [7:0]  wIdx    = wbAdr[9:2];
  wire  [1:0]  wSel    = wbSel[1:0];
  wire  [15:0] wDat    = wbDatI[15:0];
  wire  [3:0]  wSub    = wIdx[3:0];
  wire         hitFsid = wIdx[7:4] == caf_pkg::IX_FSID[7:4];
  wire         hitFeid = wIdx[7:4] == caf_pkg::IX_FEID[7:4];
  wire         hitMsid = wIdx >= caf_pkg::IX_MSID
                      && wIdx < caf_pkg::IX_MSID + 8'h03;
  wire         hitMeid = wIdx >= caf_pkg::IX_MEID
                      && wIdx < caf_pkg::IX_MEID + 8'h03;
  wire         hitBptr = wIdx[7:2] == caf_pkg::IX_BPTR[7:2];
  wire  [1:0]  mIdxS   = 2'(wIdx - caf_pkg::IX_MSID);
  wire  [1:0]  mIdxE   = 2'(wIdx - caf_pkg::IX_MEID);

  // read mux
  logic [15:0] rdVal;
  always_comb begin
    if (hitFsid) begin
      rdVal = fltStd[wSub];
    end else if (hitFeid) begin
      rdVal = fltExt[wSub];
    end else if (hitMsid) begin
      rdVal = mskStd[mIdxS] & caf_pkg::SID_WMASK;
    end else if (hitMeid) begin
      rdVal = mskExt[mIdxE];
    end else if (wIdx == caf_pkg::IX_MSEL0) begin
      rdVal = mskSel0;
    end else if (wIdx == caf_pkg::IX_MSEL1) begin
      rdVal = mskSel1;
    end else if (wIdx == caf_pkg::IX_FEN) begin
      rdVal = filter_accept_enable;
    end else if (hitBptr) begin
      rdVal = bufPtr[wIdx[1:0]];
    end else if (wIdx == caf_pkg::IX_FUL0) begin
      rdVal = fullFlags[15:0];
    end else if (wIdx == caf_pkg::IX_FUL1) begin
      rdVal = fullFlags[31:16];
    end else if (wIdx == caf_pkg::IX_OVF0) begin
      rdVal = ovfFlags[15:0];
    end else if (wIdx == caf_pkg::IX_OVF1) begin
      rdVal = ovfFlags[31:16];
    end else begin
      rdVal = caf_pkg::RST_ZERO;
    end
  end

  // per-filter match vector and priority pick
  logic [15:0] hitVec;
  logic        anyHit;
  logic [3:0]  hitNum;
  always_comb begin
    logic [1:0] code;
    logic [1:0] mIdx;
    logic [31:0] selWord;
    code    = 2'h0;
    mIdx    = 2'h0;
    hitVec  = 16'h0000;
    anyHit  = 1'b0;
    hitNum  = 4'h0;
    selWord = {mskSel1, mskSel0};
    for (int k = 0; k < caf_pkg::NUM_FILT; k++) begin
      code = selWord[2*k +: 2];
      // code 11 treated as mask 2; software must avoid it
      mIdx = maskPick(code);
      hitVec[k] = filterHit(fltStd[k], fltExt[k], mskStd[mIdx],
                            mskExt[mIdx], filter_accept_enable[k]);
    end
    // lowest filter number wins, so scan downward
    for (int k = caf_pkg::NUM_FILT - 1; k >= 0; k--) begin
      if (hitVec[k]) begin
        anyHit = 1'b1;
        hitNum = 4'(k);
      end
    end
  end

  // destination buffer of the accepted message
  wire  [3:0]  hitPtr  = bufPtr[hitNum[3:2]][4*hitNum[1:0] +: 4];
  wire  [4:0]  dstBuf  = (hitPtr == caf_pkg::PTR_FIFO)
                         ? fifoBufIdx : {1'b0, hitPtr};
  wire         doWrite = msgValid && anyHit;
  wire  [31:0] setFull = doWrite ? (32'h1 << dstBuf) : 32'h0;
  wire  [31:0] setOvf  = setFull & fullFlags;

  // wishbone answer: one wait state, ack for one cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      wbAck <= 1'b0;
    end else if (ce) begin
      wbAck <= busReq && !wbAck;
    end
  end

  // read data registered while the request waits
  always_ff @(posedge clk) begin
    if (srst) begin
      wbDatO <= 32'h0000_0000;
    end else if (ce) begin
      wbDatO <= {16'h0000, rdVal};
    end
  end

  // write strobes of the configuration registers
  wire         wrFsid  = busWr && hitFsid;
  wire         wrFeid  = busWr && hitFeid;
  wire         wrMsid  = busWr && hitMsid;
  wire         wrMeid  = busWr && hitMeid;
  wire         wrSel0  = busWr && wIdx == caf_pkg::IX_MSEL0;
  wire         wrSel1  = busWr && wIdx == caf_pkg::IX_MSEL1;
  wire         wrFen   = busWr && wIdx == caf_pkg::IX_FEN;
  wire         wrBptr  = busWr && hitBptr;

  // filter standard id words, unbuilt bits held at zero
  always_ff @(posedge clk) begin
    if (srst) begin
      for (int k = 0; k < caf_pkg::NUM_FILT; k++) begin
        fltStd[k] <= caf_pkg::RST_ZERO;
      end
    end else if (ce && wrFsid) begin
      fltStd[wSub] <= laneMerge(fltStd[wSub], wDat, wSel)
                      & caf_pkg::SID_WMASK;
    end
  end

  // filter extended id low words
  always_ff @(posedge clk) begin
    if (srst) begin
      for (int k = 0; k < caf_pkg::NUM_FILT; k++) begin
        fltExt[k] <= caf_pkg::RST_ZERO;
      end
    end else if (ce && wrFeid) begin
      fltExt[wSub] <= laneMerge(fltExt[wSub], wDat, wSel);
    end
  end

  // mask standard id words, unbuilt bits held at zero
  always_ff @(posedge clk) begin
    if (srst) begin
      for (int m = 0; m < caf_pkg::NUM_MASK; m++) begin
        mskStd[m] <= caf_pkg::RST_ZERO;
      end
    end else if (ce && wrMsid) begin
      mskStd[mIdxS] <= laneMerge(mskStd[mIdxS], wDat, wSel)
                       & caf_pkg::SID_WMASK;
    end
  end

  // mask extended id low words
  always_ff @(posedge clk) begin
    if (srst) begin
      for (int m = 0; m < caf_pkg::NUM_MASK; m++) begin
        mskExt[m] <= caf_pkg::RST_ZERO;
      end
    end else if (ce && wrMeid) begin
      mskExt[mIdxE] <= laneMerge(mskExt[mIdxE], wDat, wSel);
    end
  end

  // mask source selectors of filters 0-7 and 8-15
  always_ff @(posedge clk) begin
    if (srst) begin
      mskSel0 <= caf_pkg::RST_ZERO;
      mskSel1 <= caf_pkg::RST_ZERO;
    end else if (ce && wrSel0) begin
      mskSel0 <= laneMerge(mskSel0, wDat, wSel);
    end else if (ce && wrSel1) begin
      mskSel1 <= laneMerge(mskSel1, wDat, wSel);
    end
  end

  // filter enables, all on after reset
  always_ff @(posedge clk) begin
    if (srst) begin
      filter_accept_enable <= caf_pkg::RST_FEN;
    end else if (ce && wrFen) begin
      filter_accept_enable <= laneMerge(filter_accept_enable, wDat, wSel);
    end
  end

  // buffer pointer words, four filters each
  always_ff @(posedge clk) begin
    if (srst) begin
      for (int p = 0; p < 4; p++) begin
        bufPtr[p] <= caf_pkg::RST_ZERO;
      end
    end else if (ce && wrBptr) begin
      bufPtr[wIdx[1:0]] <= laneMerge(bufPtr[wIdx[1:0]], wDat, wSel);
    end
  end

  // full and overflow flags: hardware sets, software clears
  wire wrFul0 = busWr && wIdx == caf_pkg::IX_FUL0;
  wire wrFul1 = busWr && wIdx == caf_pkg::IX_FUL1;
  wire wrOvf0 = busWr && wIdx == caf_pkg::IX_OVF0;
  wire wrOvf1 = busWr && wIdx == caf_pkg::IX_OVF1;

  // full flags, set on every buffer write
  always_ff @(posedge clk) begin
    if (srst) begin
      fullFlags <= 32'h0000_0000;
    end else if (ce) begin
      fullFlags <= {clrSet(fullFlags[31:16], wDat, wSel, wrFul1,
                           setFull[31:16]),
                    clrSet(fullFlags[15:0], wDat, wSel, wrFul0,
                           setFull[15:0])};
    end
  end

  // overflow flags, set on a write to a buffer still full
  always_ff @(posedge clk) begin
    if (srst) begin
      ovfFlags <= 32'h0000_0000;
    end else if (ce) begin
      ovfFlags <= {clrSet(ovfFlags[31:16], wDat, wSel, wrOvf1,
                          setOvf[31:16]),
                   clrSet(ovfFlags[15:0], wDat, wSel, wrOvf0,
                          setOvf[15:0])};
    end
  end

  // acceptance pulse, one cycle per accepted message
  always_ff @(posedge clk) begin
    if (srst) begin
      accValid <= 1'b0;
    end else if (ce) begin
      accValid <= doWrite;
    end
  end

  // filter and buffer of the last accept, held until the next
  always_ff @(posedge clk) begin
    if (srst) begin
      accFilter <= 4'h0;
      accBuffer <= 5'h00;
    end else if (ce && doWrite) begin
      accFilter <= hitNum;
      accBuffer <= dstBuf;
    end
  end

endmodule // caf_rx_filter
